// file: rtl/mbm_consts.vh
`ifndef MBM_CONSTS_VH
`define MBM_CONSTS_VH
// Instruction codes on cmd_op_i
`define MBM_OP_APPEND   2'h0
`define MBM_OP_COPY     2'h1
`define MBM_OP_REVCOPY  2'h2
`define MBM_OP_XOR      2'h3
// Widths
`define MBM_AW          12
`define MBM_CW          8
// RAM holds this many bytes; a block must end at or below it
`define MBM_RAM_BYTES   13'h0300
// Transmit queue depth in bytes
`define MBM_TXQ_DEPTH   9'h080
// Status byte field positions
`define MBM_ST_BUSY_L   0
`define MBM_ST_BUSY_H   1
`define MBM_ST_OVF      2
`define MBM_ST_ADDR     3
`define MBM_ST_ARG      4
`define MBM_ST_BUSYERR  5
`endif

// file: rtl/mbm_range_check.v
`timescale 1ns/1ps
`default_nettype none
`include "mbm_consts.vh"
// Flags a block of count bytes at base that would pass the end of RAM
module mbm_range_check (
  input  wire [11:0] base_i,
  input  wire [7:0]  count_i,
  output wire        bad_o
);
  wire [12:0] end_w;

  // One past the last byte touched
  assign end_w = {1'b0, base_i} + {5'h00, count_i};
  assign bad_o = (end_w > `MBM_RAM_BYTES);
endmodule
`default_nettype wire

// file: rtl/mbm_move_unit.v
// Functional notes
// - Append reads count RAM bytes from source and pushes them to queue tail in order.
// - During append transfer, fill answer carries transmit queue fill, registered one cycle late.
// - Priority bit zero picks low slot, one picks high slot.
// - Queue full mid-append raises overflow and reports bytes not yet moved.
// - Every ended instruction pulses the finished event of its own priority.
// - Issue into an occupied slot raises the busy fault and is not started.
// - Block copy moves count bytes source to destination, order kept.
// - Reversed copy writes source plus n to destination plus count minus one minus n.
// - Block XOR writes source XOR destination back into destination, byte by byte.
`timescale 1ns/1ps
`default_nettype none
`include "mbm_consts.vh"
module mbm_move_unit (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  // Instruction port from the serial command decoder
  input  wire        cmd_valid_i,
  input  wire [1:0]  cmd_op_i,
  input  wire        cmd_prio_i,
  input  wire [11:0] cmd_src_i,
  input  wire [11:0] cmd_dst_i,
  input  wire [7:0]  cmd_count_i,
  output reg  [7:0]  cmd_status_o,
  output reg  [7:0]  cmd_fill_o,
  // RAM port, one-cycle read latency
  output reg         ram_rd_o,
  output reg         ram_wr_o,
  output reg  [11:0] ram_addr_o,
  output reg  [7:0]  ram_wdata_o,
  input  wire [7:0]  ram_rdata_i,
  // Transmit queue push side
  output reg         txq_push_o,
  output reg  [7:0]  txq_data_o,
  input  wire [7:0]  txq_fill_i,
  input  wire        txq_full_i,
  // Events, one-cycle pulses, and the held remaining byte count
  output reg         low_priority_finished_event_o,
  output reg         high_priority_finished_event_o,
  output reg         priority_slot_busy_fault_o,
  output reg         address_range_fault_o,
  output reg         bad_argument_fault_o,
  output reg         txq_overflow_event_o,
  output reg  [7:0]  remaining_o
);
  // One-hot engine states
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_RD1  = 4'h2;
  localparam [3:0] S_RD2  = 4'h4;
  localparam [3:0] S_WR   = 4'h8;

  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_n;
  reg  [3:0] state_q;
  reg        cur_prio_q;
  reg  [1:0] cur_op_q;
  reg [11:0] src_q;
  reg [11:0] dst_q;
  reg  [7:0] cnt_q;
  reg  [7:0] idx_q;
  reg  [7:0] a_byte_q;
  reg  [1:0] pend_q;       // Waiting instruction per slot
  reg  [1:0] pend_op_q [0:1];
  reg [11:0] pend_src_q [0:1];
  reg [11:0] pend_dst_q [0:1];
  reg  [7:0] pend_cnt_q [0:1];
  wire       src_bad;
  wire       dst_bad;
  wire       slot_busy;
  wire       pick;
  wire       last;
  wire       txq_stop;

  // Reset release through two flops
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  mbm_range_check u_src_chk (
    .base_i  (cmd_src_i),
    .count_i (cmd_count_i),
    .bad_o   (src_bad)
  );
  mbm_range_check u_dst_chk (
    .base_i  (cmd_dst_i),
    .count_i (cmd_count_i),
    .bad_o   (dst_bad)
  );

  // Slot taken if waiting or running at that priority
  function slot_taken;
    input       prio;
    input [1:0] pend;
    input [3:0] st;
    input       run_prio;
    begin
      slot_taken = pend[prio] | ((st != S_IDLE) & (run_prio == prio));
    end
  endfunction

  assign slot_busy = slot_taken(cmd_prio_i, pend_q, state_q, cur_prio_q);
  assign pick      = pend_q[1] ? 1'b1 : 1'b0;                          // High slot first
  assign last      = (idx_q + 8'h01 == cnt_q);
  assign txq_stop  = (cur_op_q == `MBM_OP_APPEND) & txq_full_i;      // Full before push

  // Fill is a registered copy of the queue count
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_fill_o <= 8'h00;
    end else begin
      cmd_fill_o <= txq_fill_i;
    end
  end

  // Issue, priority slots and data engine
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q                        <= S_IDLE;
      cur_prio_q                     <= 1'b0;
      cur_op_q                       <= 2'h0;
      src_q                          <= 12'h000;
      dst_q                          <= 12'h000;
      cnt_q                          <= 8'h00;
      idx_q                          <= 8'h00;
      a_byte_q                       <= 8'h00;
      pend_q                         <= 2'h0;
      pend_op_q[0]                   <= 2'h0;
      pend_op_q[1]                   <= 2'h0;
      pend_src_q[0]                  <= 12'h000;
      pend_src_q[1]                  <= 12'h000;
      pend_dst_q[0]                  <= 12'h000;
      pend_dst_q[1]                  <= 12'h000;
      pend_cnt_q[0]                  <= 8'h00;
      pend_cnt_q[1]                  <= 8'h00;
      cmd_status_o                   <= 8'h00;
      ram_rd_o                       <= 1'b0;
      ram_wr_o                       <= 1'b0;
      ram_addr_o                     <= 12'h000;
      ram_wdata_o                    <= 8'h00;
      txq_push_o                     <= 1'b0;
      txq_data_o                     <= 8'h00;
      low_priority_finished_event_o  <= 1'b0;
      high_priority_finished_event_o <= 1'b0;
      priority_slot_busy_fault_o     <= 1'b0;
      address_range_fault_o          <= 1'b0;
      bad_argument_fault_o           <= 1'b0;
      txq_overflow_event_o           <= 1'b0;
      remaining_o                    <= 8'h00;
    end else begin
      // Pulses default low
      ram_rd_o                       <= 1'b0;
      ram_wr_o                       <= 1'b0;
      txq_push_o                     <= 1'b0;
      low_priority_finished_event_o  <= 1'b0;
      high_priority_finished_event_o <= 1'b0;
      priority_slot_busy_fault_o     <= 1'b0;
      address_range_fault_o          <= 1'b0;
      bad_argument_fault_o           <= 1'b0;
      txq_overflow_event_o           <= 1'b0;

      // Status byte answered during every instruction transfer
      cmd_status_o[`MBM_ST_BUSY_L] <= slot_taken(1'b0, pend_q, state_q, cur_prio_q);
      cmd_status_o[`MBM_ST_BUSY_H] <= slot_taken(1'b1, pend_q, state_q, cur_prio_q);
      cmd_status_o[7:6]            <= 2'h0;

      // Accept or refuse a new instruction
      if (cmd_valid_i) begin
        cmd_status_o[`MBM_ST_BUSYERR] <= slot_busy;
        cmd_status_o[`MBM_ST_ADDR]    <= 1'b0;
        cmd_status_o[`MBM_ST_ARG]     <= 1'b0;
        cmd_status_o[`MBM_ST_OVF]     <= 1'b0;
        if (slot_busy) begin
          priority_slot_busy_fault_o <= 1'b1;                           // Not started
        end else if (src_bad || (cmd_op_i != `MBM_OP_APPEND && dst_bad)) begin
          address_range_fault_o       <= 1'b1;
          cmd_status_o[`MBM_ST_ADDR] <= 1'b1;
          low_priority_finished_event_o  <= ~cmd_prio_i;
          high_priority_finished_event_o <= cmd_prio_i;
        end else if (cmd_op_i == `MBM_OP_APPEND
                     && {1'b0, cmd_count_i} > (`MBM_TXQ_DEPTH - 9'h001)) begin
          bad_argument_fault_o       <= 1'b1;
          cmd_status_o[`MBM_ST_ARG] <= 1'b1;
          low_priority_finished_event_o  <= ~cmd_prio_i;
          high_priority_finished_event_o <= cmd_prio_i;
        end else if (cmd_count_i == 8'h00) begin
          low_priority_finished_event_o  <= ~cmd_prio_i;                // Empty block
          high_priority_finished_event_o <= cmd_prio_i;
        end else begin
          pend_q[cmd_prio_i]     <= 1'b1;
          pend_op_q[cmd_prio_i]  <= cmd_op_i;
          pend_src_q[cmd_prio_i] <= cmd_src_i;
          pend_dst_q[cmd_prio_i] <= cmd_dst_i;
          pend_cnt_q[cmd_prio_i] <= cmd_count_i;
        end
      end

      case (state_q)
        S_IDLE: begin
          if (pend_q != 2'h0) begin
            state_q      <= S_RD1;
            cur_prio_q   <= pick;
            cur_op_q     <= pend_op_q[pick];
            src_q        <= pend_src_q[pick];
            dst_q        <= pend_dst_q[pick];
            cnt_q        <= pend_cnt_q[pick];
            idx_q        <= 8'h00;
            pend_q[pick] <= 1'b0;
          end
        end
        S_RD1: begin
          // Source byte read
          ram_rd_o   <= 1'b1;
          ram_addr_o <= src_q + {4'h0, idx_q};
          state_q    <= (cur_op_q == `MBM_OP_XOR) ? S_RD2 : S_WR;
        end
        S_RD2: begin
          // Destination byte read for XOR
          a_byte_q   <= ram_rdata_i;
          ram_rd_o   <= 1'b1;
          ram_addr_o <= dst_q + {4'h0, idx_q};
          state_q    <= S_WR;
        end
        S_WR: begin
          if (txq_stop) begin
            // Checked here, where every earlier push is counted, so none is dropped
            txq_overflow_event_o      <= 1'b1;
            cmd_status_o[`MBM_ST_OVF] <= 1'b1;
            remaining_o               <= cnt_q - idx_q;
            if (cur_prio_q) begin
              high_priority_finished_event_o <= 1'b1;
            end else begin
              low_priority_finished_event_o <= 1'b1;
            end
            state_q                   <= S_IDLE;
          end else if (cur_op_q == `MBM_OP_APPEND) begin
            txq_push_o <= 1'b1;                                         // Append in order
            txq_data_o <= ram_rdata_i;
          end else begin
            ram_wr_o <= 1'b1;
            case (cur_op_q)
              `MBM_OP_REVCOPY: begin
                ram_addr_o  <= dst_q + {4'h0, cnt_q - 8'h01 - idx_q};
                ram_wdata_o <= ram_rdata_i;
              end
              `MBM_OP_XOR: begin
                ram_addr_o  <= dst_q + {4'h0, idx_q};
                ram_wdata_o <= a_byte_q ^ ram_rdata_i;
              end
              default: begin
                ram_addr_o  <= dst_q + {4'h0, idx_q};
                ram_wdata_o <= ram_rdata_i;
              end
            endcase
          end
          idx_q <= idx_q + 8'h01;
          // Set-only events, so a fault event of the other slot in this cycle survives
          if (!txq_stop && last) begin
            remaining_o <= 8'h00;
            if (cur_prio_q) begin
              high_priority_finished_event_o <= 1'b1;
            end else begin
              low_priority_finished_event_o <= 1'b1;
            end
            state_q <= S_IDLE;
          end else if (!txq_stop) begin
            state_q <= S_RD1;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/mbm_move_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbm_consts.vh"
module mbm_move_unit_chk (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic       cmd_prio_i,
  input wire logic [7:0] cmd_count_i,
  input wire logic [7:0] cmd_status_o,
  input wire logic [7:0] cmd_fill_o,
  input wire logic       ram_rd_o,
  input wire logic       ram_wr_o,
  input wire logic       txq_push_o,
  input wire logic [7:0] txq_fill_i,
  input wire logic       txq_full_i,
  input wire logic       low_priority_finished_event_o,
  input wire logic       high_priority_finished_event_o,
  input wire logic       priority_slot_busy_fault_o,
  input wire logic       address_range_fault_o,
  input wire logic       bad_argument_fault_o,
  input wire logic       txq_overflow_event_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Either operand fault
  sequence s_fault;
    address_range_fault_o || bad_argument_fault_o;
  endsequence
  // Operand faults end the job at once with the event of its priority
  a_fault_finish: assert property (s_fault |-> ($past(cmd_prio_i) ?
    high_priority_finished_event_o : low_priority_finished_event_o)) else $error("no finish");
  a_fault_cause: assert property (s_fault |-> $past(cmd_valid_i))
    else $error("fault without instruction");
  a_arg_cause: assert property (bad_argument_fault_o |-> $past(cmd_op_i) == `MBM_OP_APPEND
    && $past(cmd_count_i) > 8'h7F) else $error("bad argument fault wrong");
  a_busy_cause: assert property (priority_slot_busy_fault_o |-> $past(cmd_valid_i)
    && cmd_status_o[`MBM_ST_BUSYERR]) else $error("busy fault wrong");
  a_wr_after_rd: assert property (ram_wr_o |-> $past(ram_rd_o))
    else $error("write without read");
  a_push_after_rd: assert property (txq_push_o |-> $past(ram_rd_o) && !ram_wr_o)
    else $error("push without read");
  a_fill_echo: assert property (##1 cmd_fill_o == $past(txq_fill_i))
    else $error("fill answer wrong");
  a_ovf_cause: assert property (txq_overflow_event_o |-> $past(txq_full_i))
    else $error("overflow without full queue");
  a_rd_wr_apart: assert property (!(ram_rd_o && ram_wr_o))
    else $error("read and write together");
endmodule
bind mbm_move_unit mbm_move_unit_chk mbm_move_unit_chk_i (.sys_clk_i, .rst_n_i, .cmd_valid_i,
  .cmd_op_i, .cmd_prio_i, .cmd_count_i, .cmd_status_o, .cmd_fill_o, .ram_rd_o, .ram_wr_o,
  .txq_push_o, .txq_fill_i, .txq_full_i, .low_priority_finished_event_o,
  .high_priority_finished_event_o, .priority_slot_busy_fault_o, .address_range_fault_o,
  .bad_argument_fault_o, .txq_overflow_event_o);
`default_nettype wire

// file: tb/mbm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbm_mem_model #(parameter int DEPTH = 128) (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output var  logic [7:0]  rdata_o,
  input  wire logic        push_i,
  input  wire logic [7:0]  push_data_i,
  output var  logic [7:0]  fill_o,
  output wire logic        full_o
);
  logic [7:0] mem [0:767];
  logic [7:0] txq [0:255];
  initial fill_o = 8'h00;
  initial rdata_o = 8'h00;
  // Read answers on the falling edge, ready at the engine's next rising edge;
  // idle cycles show a changing pattern so that a stale sample is caught
  always @(negedge clk_i) begin
    rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
  end
  // Writes and queue pushes land on the rising edge
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    if (push_i && !full_o) begin
      txq[fill_o] <= push_data_i;
      fill_o <= fill_o + 8'h01;
    end
  end
  assign full_o = (fill_o == DEPTH[7:0]);
endmodule
`default_nettype wire

// file: tb/mbm_move_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbm_consts.vh"
module mbm_move_unit_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic prio = 1'b0;
  logic [1:0] op = 2'h0;
  logic [11:0] src = 12'h000;
  logic [11:0] dst = 12'h000;
  logic [7:0] cnt = 8'h00;
  wire logic [7:0] status, fill, rdata, wdata, pdata, qfill, rem;
  wire logic [11:0] addr;
  wire logic rd, wr, push, full, ev_l, ev_h, f_busy, f_addr, f_arg, ovf;
  logic [3:0] seen;
  int mismatches = 0;
  int cmp_count = 0;
  always #4 sys_clk = ~sys_clk;
  mbm_move_unit mbm_move_unit_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cmd_valid_i(valid),
    .cmd_op_i(op), .cmd_prio_i(prio), .cmd_src_i(src), .cmd_dst_i(dst), .cmd_count_i(cnt),
    .cmd_status_o(status), .cmd_fill_o(fill), .ram_rd_o(rd), .ram_wr_o(wr), .ram_addr_o(addr),
    .ram_wdata_o(wdata), .ram_rdata_i(rdata), .txq_push_o(push), .txq_data_o(pdata),
    .txq_fill_i(qfill), .txq_full_i(full), .low_priority_finished_event_o(ev_l),
    .high_priority_finished_event_o(ev_h), .priority_slot_busy_fault_o(f_busy),
    .address_range_fault_o(f_addr), .bad_argument_fault_o(f_arg),
    .txq_overflow_event_o(ovf), .remaining_o(rem));
  // Small queue so that overflow is reachable
  mbm_mem_model #(.DEPTH(6)) mbm_mem_model_i (.clk_i(sys_clk), .rd_i(rd), .wr_i(wr),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .push_i(push), .push_data_i(pdata),
    .fill_o(qfill), .full_o(full));
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input int n);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: check %0d", $time, n);
    end
  endtask
  task automatic issue(input logic [1:0] o, input logic p, input logic [11:0] s, d,
                       input logic [7:0] c);
    @(negedge sys_clk);
    {valid, op, prio, src, dst, cnt} = {1'b1, o, p, s, d, c};
    @(negedge sys_clk);
    valid = 1'b0;
  endtask
  // Waits for the finish event of one priority, gathering faults on the way
  task automatic run(input logic [1:0] o, input logic p, input logic [11:0] s, d,
                     input logic [7:0] c);
    issue(o, p, s, d, c);
    seen = 4'h0;
    for (int k = 0; k < 3000; k++) begin
      seen = seen | {f_busy, f_arg, f_addr, ovf};
      if ((p ? ev_h : ev_l) === 1'b1) begin
        // One more edge lets the last write or push land
        @(negedge sys_clk);
        return;
      end
      @(negedge sys_clk);
    end
    mismatches++;
    $display("wrong value at %0t: timeout", $time);
    conclude();
  endtask
  task automatic t_moves();
    run(`MBM_OP_COPY, 1'b0, 12'h100, 12'h200, 8'h04);
    for (int i = 0; i < 4; i++) chk(mbm_mem_model_i.mem[12'h200 + i] === 8'hA0 + i, 1);
    run(`MBM_OP_REVCOPY, 1'b1, 12'h100, 12'h210, 8'h04);
    for (int i = 0; i < 4; i++) chk(mbm_mem_model_i.mem[12'h213 - i] === 8'hA0 + i, 2);
    run(`MBM_OP_XOR, 1'b0, 12'h100, 12'h220, 8'h04);
    for (int i = 0; i < 4; i++)
      chk(mbm_mem_model_i.mem[12'h220 + i] === ((8'hA0 + i) ^ 8'h5A), 3);
  endtask
  task automatic t_queue();
    run(`MBM_OP_APPEND, 1'b1, 12'h100, 12'h000, 8'h03);
    for (int i = 0; i < 3; i++) chk(mbm_mem_model_i.txq[i] === 8'hA0 + i, 4);
    @(negedge sys_clk);
    chk(fill === 8'h03, 5);
    run(`MBM_OP_APPEND, 1'b0, 12'h104, 12'h000, 8'h05);
    chk(seen[0] === 1'b1 && rem === 8'h02 && status[`MBM_ST_OVF] === 1'b1, 6);
    for (int i = 0; i < 3; i++) chk(mbm_mem_model_i.txq[3 + i] === 8'hA4 + i, 7);
  endtask
  task automatic t_faults();
    run(`MBM_OP_COPY, 1'b0, 12'h100, 12'h2FF, 8'h02);
    chk(seen[1] === 1'b1 && status[`MBM_ST_ADDR] === 1'b1, 8);
    run(`MBM_OP_COPY, 1'b1, 12'h100, 12'h2FE, 8'h02);
    chk(seen === 4'h0 && mbm_mem_model_i.mem[12'h2FF] === 8'hA1, 9);
    run(`MBM_OP_APPEND, 1'b1, 12'h100, 12'h000, 8'h80);
    chk(seen[2] === 1'b1 && status[`MBM_ST_ARG] === 1'b1, 10);
  endtask
  task automatic t_busy();
    issue(`MBM_OP_COPY, 1'b0, 12'h100, 12'h240, 8'h3C);
    issue(`MBM_OP_COPY, 1'b0, 12'h100, 12'h280, 8'h04);
    chk(f_busy === 1'b1 && status[`MBM_ST_BUSYERR] === 1'b1, 11);
    chk(status[`MBM_ST_BUSY_L] === 1'b1, 13);
    run(`MBM_OP_COPY, 1'b1, 12'h104, 12'h2C0, 8'h02);
    chk(mbm_mem_model_i.mem[12'h2C0] === 8'hA4, 12);
    chk(mbm_mem_model_i.mem[12'h280] === 8'h00, 12);
  endtask
  initial begin
    for (int i = 0; i < 768; i++) mbm_mem_model_i.mem[i] = 8'h00;
    for (int i = 0; i < 8; i++) mbm_mem_model_i.mem[12'h100 + i] = 8'hA0 + i;
    for (int i = 0; i < 4; i++) mbm_mem_model_i.mem[12'h220 + i] = 8'h5A;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_moves();
    t_queue();
    t_faults();
    t_busy();
    conclude();
  end
endmodule
`default_nettype wire
